// File: src/sacs_pkg.sv
package sacs_pkg;
   localparam int REF_CLK_HZ     = 40_000_000;
   localparam int ADC_CLK_MAX_HZ = 18_000_000;
   // Least divide ratio that keeps the converter clock at or below its limit.
   localparam int CONV_DIV       = (REF_CLK_HZ + ADC_CLK_MAX_HZ - 1)
                                   / ADC_CLK_MAX_HZ;
   localparam int CONV_CLKS      = 18;
   localparam int SAR_BITS       = 12;
   localparam int NUM_CH         = 8;
   localparam int CH_W           = 3;
   localparam int ST_W           = 4;
   localparam int DIV_W          = 2;
   localparam int CNT_W          = 5;
   localparam logic [ST_W-1:0]     SAMPLE_MIN = 4'h1;
   localparam logic [SAR_BITS-1:0] DAC_MID    = 12'h800;
   localparam logic [SAR_BITS-1:0] RESULT_RST = 12'h000;
   localparam logic [CH_W-1:0]     CH_RST     = 3'h0;
   localparam logic [CNT_W-1:0]    CNT_RST    = 5'h00;
   localparam logic [DIV_W-1:0]    DIV_RST    = 2'h0;

   typedef enum logic [1:0] {
      SACS_IDLE,
      SACS_SAMPLE,
      SACS_CONVERT
   } sacs_state_e;
endpackage

// File: src/sacs_result_mem.sv
`timescale 1ns/1ps
module sacs_result_mem (
   input  wire logic                          ref_clk,
   input  wire logic                          rst_n,
   input  wire logic                          wr_en,
   input  wire logic [sacs_pkg::CH_W-1:0]     wr_addr,
   input  wire logic [sacs_pkg::SAR_BITS-1:0] wr_data,
   input  wire logic [sacs_pkg::CH_W-1:0]     rd_addr,
   output logic      [sacs_pkg::SAR_BITS-1:0] rd_data
);
   import sacs_pkg::*;

   logic [SAR_BITS-1:0] mem_reg [NUM_CH];

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_CH; i++) begin
            mem_reg[i] <= RESULT_RST;
         end
      end else if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= RESULT_RST;
      end else begin
         rd_data <= mem_reg[rd_addr];
      end
   end
endmodule

// File: src/sacs_sequencer.sv
// What this block does
// - Converter clock at most 18 MHz; conversion spans 18 converter clocks.
// - Sample-and-hold acquisition window length is programmable.
// - Eight-input sequencer steps through enabled channels on its own.
// - No idle cycles between channels; result spacing varies with each channel's sample time.
// - Channel chosen by the scan machine or directly by firmware.
// - Separate result buffer kept for every channel.
// - Each channel's own sample time is applied when it is acquired.
// - Out-of-window result raises the range interrupt at once.
// - Converter and sequencer are halted during deep sleep.
`timescale 1ns/1ps
module sacs_sequencer (
   input  wire logic                               ref_clk,
   input  wire logic                               rst_n,
   input  wire logic                               enable,
   input  wire logic                               deep_sleep,
   input  wire logic                               start,
   input  wire logic                               continuous,
   input  wire logic [sacs_pkg::NUM_CH-1:0]        ch_enable,
   input  wire logic                               fw_mode,
   input  wire logic [sacs_pkg::CH_W-1:0]          fw_channel,
   input  wire logic [sacs_pkg::NUM_CH*sacs_pkg::ST_W-1:0] sample_times,
   input  wire logic [sacs_pkg::SAR_BITS-1:0]      limit_low,
   input  wire logic [sacs_pkg::SAR_BITS-1:0]      limit_high,
   input  wire logic                               comp_in,
   input  wire logic [sacs_pkg::CH_W-1:0]          rd_ch,
   output logic      [sacs_pkg::SAR_BITS-1:0]      rd_data,
   output logic      [sacs_pkg::CH_W-1:0]          mux_sel_reg,
   output logic                                    sh_sample_reg,
   output logic      [sacs_pkg::SAR_BITS-1:0]      sar_dac_reg,
   output logic                                    busy_reg,
   output logic                                    result_valid_reg,
   output logic      [sacs_pkg::CH_W-1:0]          result_ch_reg,
   output logic      [sacs_pkg::SAR_BITS-1:0]      result_data_reg,
   output logic                                    range_irq_reg,
   output logic                                    scan_done_reg
);
   import sacs_pkg::*;

   sacs_state_e         state_reg;
   logic [DIV_W-1:0]    div_reg;
   logic                conv_tick;
   logic [CNT_W-1:0]    tick_reg;
   logic [NUM_CH-1:0]   mask_reg;
   logic                fw_q_reg;
   logic                cont_q_reg;
   logic                comp_meta_reg;
   logic                comp_sync_reg;
   logic [3:0]          bit_idx;
   logic                conv_done;
   logic [3:0]          after_pick;
   logic [3:0]          first_pick;
   logic [3:0]          start_pick;
   logic                last_ch;
   logic                go;

   // Lowest enabled channel at or above from; bit 3 set when none is found.
   function automatic logic [3:0] pick_ch(input logic [NUM_CH-1:0] mask,
                                          input logic [3:0] from);
      logic [3:0] r;
      r = 4'h8;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (mask[i] && (4'(i) >= from)) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [ST_W-1:0] st_of(input logic [CH_W-1:0] ch,
      input logic [NUM_CH*ST_W-1:0] times);
      logic [ST_W-1:0] t;
      t = times[ch*ST_W +: ST_W];
      return (t < SAMPLE_MIN) ? SAMPLE_MIN : t;
   endfunction

   function automatic logic out_of_range(input logic [SAR_BITS-1:0] v,
      input logic [SAR_BITS-1:0] lo, input logic [SAR_BITS-1:0] hi);
      return (v < lo) || (v > hi);
   endfunction

   // The comparator output is analog and asynchronous to ref_clk.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         comp_meta_reg <= 1'b0;
         comp_sync_reg <= 1'b0;
      end else begin
         comp_meta_reg <= comp_in;
         comp_sync_reg <= comp_meta_reg;
      end
   end

   // Converter clock enable; stopped in deep sleep.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= DIV_RST;
      end else if (deep_sleep) begin
         div_reg <= DIV_RST;
      end else if (div_reg == DIV_W'(CONV_DIV - 1)) begin
         div_reg <= DIV_RST;
      end else begin
         div_reg <= div_reg + 2'h1;
      end
   end

   assign conv_tick  = !deep_sleep && (div_reg == DIV_W'(CONV_DIV - 1));
   assign bit_idx    = 4'(SAR_BITS - 1) - tick_reg[3:0];
   assign conv_done  = conv_tick && (state_reg == SACS_CONVERT)
                       && (tick_reg == CNT_W'(CONV_CLKS - 1));
   assign after_pick = pick_ch(mask_reg, {1'b0, mux_sel_reg} + 4'h1);
   assign first_pick = pick_ch(mask_reg, 4'h0);
   assign start_pick = pick_ch(ch_enable, 4'h0);
   assign last_ch    = fw_q_reg || after_pick[3];
   assign go         = enable && (start || continuous)
                       && (fw_mode || (|ch_enable));

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= SACS_IDLE;
         tick_reg      <= CNT_RST;
         mux_sel_reg   <= CH_RST;
         sh_sample_reg <= 1'b0;
         sar_dac_reg   <= RESULT_RST;
         mask_reg      <= '0;
         fw_q_reg      <= 1'b0;
         cont_q_reg    <= 1'b0;
      end else if (deep_sleep || !enable) begin
         state_reg     <= SACS_IDLE;
         sh_sample_reg <= 1'b0;
      end else begin
         case (state_reg)
            SACS_IDLE: begin
               if (go) begin
                  mask_reg      <= ch_enable;
                  fw_q_reg      <= fw_mode;
                  cont_q_reg    <= continuous;
                  mux_sel_reg   <= fw_mode ? fw_channel
                                   : start_pick[CH_W-1:0];
                  state_reg     <= SACS_SAMPLE;
                  tick_reg      <= CNT_RST;
                  sh_sample_reg <= 1'b1;
               end
            end
            SACS_SAMPLE: begin
               if (conv_tick) begin
                  if (tick_reg + 5'h01 >= CNT_W'(st_of(mux_sel_reg,
                                                 sample_times))) begin
                     state_reg     <= SACS_CONVERT;
                     tick_reg      <= CNT_RST;
                     sh_sample_reg <= 1'b0;
                     sar_dac_reg   <= DAC_MID;
                  end else begin
                     tick_reg <= tick_reg + 5'h01;
                  end
               end
            end
            SACS_CONVERT: begin
               if (conv_done) begin
                  // Next channel goes straight into sampling.
                  if (!last_ch) begin
                     mux_sel_reg   <= after_pick[CH_W-1:0];
                     state_reg     <= SACS_SAMPLE;
                     sh_sample_reg <= 1'b1;
                  end else if (cont_q_reg) begin
                     mux_sel_reg   <= fw_q_reg ? fw_channel
                                      : first_pick[CH_W-1:0];
                     state_reg     <= SACS_SAMPLE;
                     sh_sample_reg <= 1'b1;
                  end else begin
                     state_reg <= SACS_IDLE;
                  end
                  tick_reg <= CNT_RST;
               end else if (conv_tick) begin
                  // One bit is decided per converter clock, MSB first;
                  // the remaining clocks complete the conversion time.
                  if (tick_reg < CNT_W'(SAR_BITS)) begin
                     if (!comp_sync_reg) begin
                        sar_dac_reg[bit_idx] <= 1'b0;
                     end
                     if (bit_idx != 4'h0) begin
                        sar_dac_reg[bit_idx - 4'h1] <= 1'b1;
                     end
                  end
                  tick_reg <= tick_reg + 5'h01;
               end
            end
            default: begin
               state_reg <= SACS_IDLE;
            end
         endcase
      end
   end

   // Result, range and scan-end pulses.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_valid_reg <= 1'b0;
         result_ch_reg    <= CH_RST;
         result_data_reg  <= RESULT_RST;
         range_irq_reg    <= 1'b0;
         scan_done_reg    <= 1'b0;
         busy_reg         <= 1'b0;
      end else begin
         result_valid_reg <= conv_done && enable;
         range_irq_reg    <= conv_done && enable && out_of_range(
                             sar_dac_reg, limit_low, limit_high);
         scan_done_reg    <= conv_done && enable && last_ch;
         busy_reg         <= (state_reg != SACS_IDLE) && !deep_sleep;
         if (conv_done) begin
            result_ch_reg   <= mux_sel_reg;
            result_data_reg <= sar_dac_reg;
         end
      end
   end

   sacs_result_mem u_mem (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .wr_en   (conv_done && enable && !deep_sleep),
      .wr_addr (mux_sel_reg),
      .wr_data (sar_dac_reg),
      .rd_addr (rd_ch),
      .rd_data (rd_data)
   );

   // Helper: cycles spent in the present conversion.
   logic [7:0] conv_cyc;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_cyc <= 8'h00;
      end else if (state_reg != SACS_CONVERT || conv_done) begin
         conv_cyc <= 8'h00;
      end else if (conv_cyc != 8'hff) begin
         conv_cyc <= conv_cyc + 8'h01;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_tick_rate;
      conv_tick |=> !conv_tick [*2];
   endproperty
   a_tick_rate: assert property (p_tick_rate)
      else $error("Converter clock enable faster than allowed.");

   property p_conv_len;
      conv_done |-> conv_cyc >= 8'd51;
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("Conversion shorter than 18 converter clocks.");

   property p_sample_len;
      (state_reg == SACS_SAMPLE) && $past(state_reg) == SACS_SAMPLE
         ##0 (state_reg == SACS_SAMPLE) ##1 (state_reg == SACS_CONVERT)
      |-> $past(tick_reg) + 5'h01
          >= 5'(st_of($past(mux_sel_reg), $past(sample_times)));
   endproperty
   a_sample_len: assert property (p_sample_len)
      else $error("Sample window ended before channel sample time.");

   property p_sh_follows;
      sh_sample_reg |-> state_reg == SACS_SAMPLE;
   endproperty
   a_sh_follows: assert property (p_sh_follows)
      else $error("Hold switch closed outside the sample phase.");

   property p_scan_enabled;
      (state_reg == SACS_SAMPLE) && !fw_q_reg |-> mask_reg[mux_sel_reg];
   endproperty
   a_scan_enabled: assert property (p_scan_enabled)
      else $error("Scan selected a disabled channel.");

   property p_no_gap;
      conv_done && enable && !deep_sleep && (!last_ch || cont_q_reg)
      |=> state_reg == SACS_SAMPLE && sh_sample_reg;
   endproperty
   a_no_gap: assert property (p_no_gap)
      else $error("Idle cycle inserted between channels.");

   property p_fw_sel;
      $rose(state_reg == SACS_SAMPLE) && fw_q_reg
      |-> mux_sel_reg == $past(fw_channel);
   endproperty
   a_fw_sel: assert property (p_fw_sel)
      else $error("Firmware channel choice not applied.");

   property p_buffer;
      result_valid_reg ##0 (rd_ch == result_ch_reg)
      |=> rd_data == $past(result_data_reg);
   endproperty
   a_buffer: assert property (p_buffer)
      else $error("Channel buffer does not hold the new result.");

   property p_range;
      result_valid_reg |-> range_irq_reg == out_of_range(result_data_reg,
                             $past(limit_low), $past(limit_high));
   endproperty
   a_range: assert property (p_range)
      else $error("Range interrupt disagrees with result and limits.");

   property p_sleep;
      deep_sleep |=> state_reg == SACS_IDLE && !sh_sample_reg
                     && !result_valid_reg;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("Sequencer active during deep sleep.");

   property p_done_last;
      scan_done_reg |-> result_valid_reg
                        && (state_reg == SACS_SAMPLE) == cont_q_reg;
   endproperty
   a_done_last: assert property (p_done_last)
      else $error("Scan done without last result or wrong wrap.");

   c_scan_done: cover property (scan_done_reg && cont_q_reg && !fw_q_reg);
   c_range: cover property (range_irq_reg);
   c_fw_conv: cover property (result_valid_reg && fw_q_reg);
   c_sleep_abort: cover property ((state_reg == SACS_CONVERT) && deep_sleep);
endmodule

// File: bench/sacs_analog_model.sv
`timescale 1ns/1ps
module sacs_analog_model (
   input  wire logic                                     ref_clk,
   input  wire logic [sacs_pkg::CH_W-1:0]                mux_sel,
   input  wire logic                                     sh_sample,
   input  wire logic [sacs_pkg::SAR_BITS-1:0]            sar_dac,
   input  wire logic [sacs_pkg::NUM_CH*sacs_pkg::SAR_BITS-1:0] levels,
   output logic                                          comp_in
);
   import sacs_pkg::*;
   logic [SAR_BITS-1:0] held;
   // The capacitor tracks only while sampling, so a late level change
   // must not leak into a conversion already under way.
   always_ff @(posedge ref_clk) begin
      if (sh_sample) begin
         held <= levels[mux_sel*SAR_BITS +: SAR_BITS];
      end
   end
   assign comp_in = (held >= sar_dac);
endmodule

// File: bench/sar_adc_channel_sequencer_tb.sv
`timescale 1ns/1ps
module sar_adc_channel_sequencer_tb;
   import sacs_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n, enable, deep_sleep, start, continuous, fw_mode, comp_in;
   logic [7:0] ch_enable;
   logic [2:0] fw_channel, rd_ch, mux_sel_reg, result_ch_reg;
   logic [31:0] sample_times;
   logic [95:0] levels;
   logic [11:0] limit_low, limit_high, rd_data, sar_dac_reg, result_data_reg;
   logic sh_sample_reg, busy_reg, result_valid_reg, range_irq_reg;
   logic scan_done_reg;
   logic [15:0] lf = 16'h0030;
   int n_fail = 0;
   int num_checks = 0;

   always #12.5 ref_clk = ~ref_clk;

   sacs_sequencer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .enable(enable),
      .deep_sleep(deep_sleep), .start(start), .continuous(continuous),
      .ch_enable(ch_enable), .fw_mode(fw_mode), .fw_channel(fw_channel),
      .sample_times(sample_times), .limit_low(limit_low),
      .limit_high(limit_high), .comp_in(comp_in), .rd_ch(rd_ch),
      .rd_data(rd_data), .mux_sel_reg(mux_sel_reg),
      .sh_sample_reg(sh_sample_reg), .sar_dac_reg(sar_dac_reg),
      .busy_reg(busy_reg), .result_valid_reg(result_valid_reg),
      .result_ch_reg(result_ch_reg), .result_data_reg(result_data_reg),
      .range_irq_reg(range_irq_reg), .scan_done_reg(scan_done_reg));

   sacs_analog_model model_u (.ref_clk(ref_clk), .mux_sel(mux_sel_reg),
      .sh_sample(sh_sample_reg), .sar_dac(sar_dac_reg), .levels(levels),
      .comp_in(comp_in));

   function automatic logic [15:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction

   function automatic int nxt(logic [7:0] m, int c);
      for (int i = 1; i <= 8; i++) begin
         if (m[(c + i) % 8]) return (c + i) % 8;
      end
      return c;
   endfunction

   function automatic int st(int c);
      logic [3:0] v;
      v = sample_times[c*4 +: 4];
      return (v == 4'h0) ? 1 : int'(v);
   endfunction

   function automatic logic outside(logic [11:0] v);
      return (v < limit_low) || (v > limit_high);
   endfunction

   task automatic end_of_test();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic bad(string m);
      n_fail++;
      $display("BAD %0t %s", $time, m);
   endtask

   task automatic chk_d(logic [11:0] got, logic [11:0] exp, string m);
      num_checks++;
      if (got !== exp) bad($sformatf("%s got %h exp %h", m, got, exp));
   endtask

   task automatic chk_f(logic got, logic exp, string m);
      num_checks++;
      if (got !== exp) bad($sformatf("%s got %b exp %b", m, got, exp));
   endtask

   task automatic chk_n(int got, int exp, int tol, string m);
      num_checks++;
      if (got < exp - tol || got > exp + tol) begin
         bad($sformatf("%s got %0d exp %0d", m, got, exp));
      end
   endtask

   task automatic shuffle();
      for (int i = 0; i < 8; i++) levels[i*12 +: 12] = 12'(rnd());
      sample_times = {rnd(), rnd()};
      limit_low    = 12'(rnd()) & 12'h7ff;
      limit_high   = 12'(rnd()) | 12'h800;
   endtask

   // Results are sampled on the falling edge, where they have settled.
   task automatic scan(logic [7:0] m, logic fw, logic [2:0] fc, logic cont,
                       int n);
      logic [7:0] em;
      int c, w;
      em = fw ? (8'h01 << fc) : m;
      @(negedge ref_clk);
      ch_enable  = m;
      fw_mode    = fw;
      fw_channel = fc;
      continuous = cont;
      start      = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      c = nxt(em, 7);
      for (int k = 0; k < n; k++) begin
         w = 0;
         do begin
            @(negedge ref_clk);
            w++;
         end while (result_valid_reg !== 1'b1 && w < 400);
         if (w >= 400) begin
            bad("no result");
            end_of_test();
         end
         if (k > 0) begin
            chk_n(w, (st(c)+18)*3, 2, "interval");
         end
         chk_d({9'h000, result_ch_reg}, 12'(c), "channel");
         chk_d(result_data_reg, levels[c*12 +: 12], "data");
         chk_f(range_irq_reg, outside(levels[c*12 +: 12]), "range");
         chk_f(scan_done_reg, nxt(em, c) <= c, "done");
         c = nxt(em, c);
      end
      if (!cont) begin
         repeat (4) @(negedge ref_clk);
         chk_f(busy_reg, 1'b0, "idle after scan");
         for (int i = 0; i < 8; i++) begin
            if (em[i]) begin
               rd_ch = 3'(i);
               @(negedge ref_clk);
               chk_d(rd_data, levels[i*12 +: 12], "buffer");
            end
         end
      end
   endtask

   task automatic halt(logic ds);
      int seen;
      seen = 0;
      @(negedge ref_clk);
      if (ds) deep_sleep = 1'b1;
      else enable = 1'b0;
      repeat (150) begin
         @(negedge ref_clk);
         if (result_valid_reg === 1'b1) seen++;
      end
      chk_n(seen, 0, 0, "result after halt");
      chk_f(busy_reg, 1'b0, "busy after halt");
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      repeat (5) @(negedge ref_clk);
      chk_f(busy_reg, 1'b0, "start while halted");
      // A continuous level left high would restart the old scan on release.
      continuous = 1'b0;
      deep_sleep = 1'b0;
      enable     = 1'b1;
   endtask

   initial begin
      rst_n = 1'b0;
      enable = 1'b1;
      deep_sleep = 1'b0;
      start = 1'b0;
      continuous = 1'b0;
      fw_mode = 1'b0;
      ch_enable = 8'h00;
      fw_channel = 3'h0;
      rd_ch = 3'h0;
      shuffle();
      repeat (8) @(negedge ref_clk);
      rst_n = 1'b1;
      @(negedge ref_clk);
      chk_f(busy_reg, 1'b0, "busy at reset");
      chk_f(result_valid_reg, 1'b0, "valid at reset");
      chk_d(rd_data, RESULT_RST, "buffer at reset");
      // Extreme codes and zero sample times at both ends of the mux.
      sample_times = 32'h0000_0000;
      levels[0 +: 12] = 12'h000;
      levels[84 +: 12] = 12'hfff;
      limit_low = 12'h001;
      limit_high = 12'hffe;
      scan(8'h81, 1'b0, 3'h0, 1'b0, 2);
      scan(8'hff, 1'b0, 3'h0, 1'b0, 8);
      for (int t = 0; t < 6; t++) begin
         shuffle();
         ch_enable = 8'(rnd());
         if (ch_enable == 8'h00) ch_enable = 8'h10;
         scan(ch_enable, 1'b0, 3'h0, 1'b0, $countones(ch_enable));
      end
      shuffle();
      scan(8'(rnd()), 1'b1, 3'(rnd()), 1'b0, 1);
      scan(8'h24, 1'b0, 3'h0, 1'b1, 5);
      halt(1'b1);
      scan(8'h00, 1'b1, 3'h6, 1'b1, 3);
      halt(1'b0);
      // A scan with an empty mask must be ignored.
      scan(8'h00, 1'b0, 3'h0, 1'b0, 0);
      end_of_test();
   end
endmodule
